// ### verilog/fpu_exc_pkg.sv
/*
 * Constants and carrier types for the floating-point exception and
 * state-restore control unit.
 * Assumes the integer pipeline presents one decoded instruction per cycle.
 */
package fpu_exc_pkg;

	localparam int OPW_W = 16;
	localparam int NREG = 8;
	localparam int EXT_W = 80;

	// instruction word pattern for state restore, bits 15:6
	localparam logic [9:0] RESTORE_PATTERN = 10'h3CD;

	// frame format codes
	localparam logic [7:0] FRAME_NULL = 8'h00;
	localparam logic [7:0] FRAME_IDLE = 8'h60;
	localparam logic [7:0] FRAME_PENDING_EXCEPTION_FRAME = 8'hE0;

	// exception vector numbers
	localparam logic [7:0] VEC_SIGNALLING_NAN_EXC = 8'h36;
	localparam logic [7:0] VEC_OPERAND_ERROR_EXC = 8'h34;
	localparam logic [7:0] VEC_UNFL = 8'h33;
	localparam logic [7:0] VEC_OVFL = 8'h35;

	// opclass codes
	localparam logic [2:0] OPCLASS_0 = 3'h0;
	localparam logic [2:0] OPCLASS_2 = 3'h2;
	localparam logic [2:0] OPCLASS_3 = 3'h3;

	// control register enable bit positions
	localparam int CTL_SIGNALLING_NAN_EXC_BIT = 14;
	localparam int CTL_OPERAND_ERROR_EXC_BIT = 13;
	localparam int CTL_OVFL_BIT = 12;
	localparam int CTL_UNFL_BIT = 11;

	// status register accrued bit positions
	localparam int STS_SIGNALLING_NAN_EXC_BIT = 14;
	localparam int STS_OPERAND_ERROR_EXC_BIT = 13;

	// default quiet nan in extended precision
	localparam logic [79:0] QUIET_NAN = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;

	// effective address mode codes
	localparam logic [2:0] EA_IND = 3'h2;
	localparam logic [2:0] EA_POSTINC = 3'h3;
	localparam logic [2:0] EA_DISP = 3'h5;
	localparam logic [2:0] EA_INDEX = 3'h6;
	localparam logic [2:0] EA_OTHER = 3'h7;
	localparam logic [2:0] EA_OTHER_MAX = 3'h3;

	typedef enum logic [1:0] {
		UNIT_IDLE,
		UNIT_PENDING
	} unit_state_t;

	// one floating-point operation issued by the integer pipeline
	typedef struct packed {
		logic [2:0] opclass;
		logic signalling_nan_exc;
		logic operand_error_exc;
		logic ovfl;
		logic unfl;
		logic [79:0] src_ext;
		logic [79:0] dst_ext;
		logic [79:0] default_result;
		logic [2:0] dst_reg;
		logic [31:0] iaddr;
	} fp_op_t;

	// state frame handed over by a restore
	typedef struct packed {
		logic [7:0] format;
		logic [7:0] vector;
	} restore_frame_t;

	// what a save instruction reads back
	typedef struct packed {
		logic valid;
		logic [7:0] format;
		logic [7:0] vector;
		logic [79:0] operand;
	} save_frame_t;

	// exception request towards the integer pipeline
	typedef struct packed {
		logic take;
		logic pre;
		logic [7:0] vector;
	} exc_req_t;

endpackage : fpu_exc_pkg

// ### verilog/restore_decode.sv
/*
 * Decoder for the state-restore instruction word and its addressing mode.
 * Assumes the word is stable while its valid strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none
module restore_decode (
	input wire logic [fpu_exc_pkg::OPW_W-1:0] i_opword,
	output logic o_is_restore,
	output logic o_mode_legal
);
	import fpu_exc_pkg::*;

	wire [2:0] ea_mode = i_opword[5:3];
	wire [2:0] ea_reg = i_opword[2:0];
	wire mode_ctl = (ea_mode == EA_IND) || (ea_mode == EA_POSTINC) ||
		(ea_mode == EA_DISP) || (ea_mode == EA_INDEX);
	wire mode_abs = (ea_mode == EA_OTHER) && (ea_reg <= EA_OTHER_MAX);

	assign o_is_restore = (i_opword[15:6] == RESTORE_PATTERN);
	assign o_mode_legal = mode_ctl || mode_abs;

endmodule : restore_decode
`default_nettype wire

// ### verilog/fpu_exception_state_restore.sv
/*
 * Floating-point exception control and internal state restore/save.
 * Assumes the integer pipeline issues at most one request per cycle and
 * supplies operand flags and the extended-precision source with it.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpu_exception_state_restore #(
	parameter int NREGS = fpu_exc_pkg::NREG
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_op_valid,
	input wire fpu_exc_pkg::fp_op_t i_op,
	input wire logic i_mul_zero_exp,
	input wire logic i_save_valid,
	input wire logic i_restore_valid,
	input wire logic [fpu_exc_pkg::OPW_W-1:0] i_restore_opword,
	input wire fpu_exc_pkg::restore_frame_t i_restore_frame,
	input wire logic i_ctl_we,
	input wire logic [31:0] i_ctl_wdata,
	input wire logic [2:0] i_reg_rsel,
	output fpu_exc_pkg::exc_req_t o_exc,
	output logic o_illegal,
	output logic o_dst_we,
	output logic [2:0] o_dst_reg,
	output logic [fpu_exc_pkg::EXT_W-1:0] o_dst_data,
	output fpu_exc_pkg::save_frame_t o_save_frame,
	output logic o_pending,
	output logic [31:0] o_fp_control_reg,
	output logic [31:0] o_fp_status_reg,
	output logic [31:0] o_fp_instr_address_reg,
	output logic [fpu_exc_pkg::EXT_W-1:0] o_reg_rdata
);
	import fpu_exc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	unit_state_t state;
	unit_state_t next_state;
	logic pend_flag;
	logic [7:0] frame_fmt;
	logic [7:0] pend_vec;
	logic [79:0] saved_src;
	logic saved_valid;
	logic [31:0] fp_control_reg;
	logic [31:0] fp_status_reg;
	logic [79:0] data_reg [NREGS];

	////////////////////////////////////////////////////////////////////////
	// decode
	logic is_restore;
	logic mode_legal;

	restore_decode u_dec (
		.i_opword(i_restore_opword),
		.o_is_restore(is_restore),
		.o_mode_legal(mode_legal)
	);

	wire do_restore = i_restore_valid && is_restore && mode_legal;
	wire bad_restore = i_restore_valid && !(is_restore && mode_legal);

	// one compare per frame kind, shared by the three restore strobes
	function automatic logic frame_is(input logic [7:0] fmt,
		input logic [7:0] code);
		return fmt == code;
	endfunction : frame_is

	// an unknown format with a legal mode matches none of these
	wire rest_null = do_restore &&
		frame_is(i_restore_frame.format, FRAME_NULL);
	wire rest_idle = do_restore &&
		frame_is(i_restore_frame.format, FRAME_IDLE);
	wire rest_pending_exception_frame = do_restore &&
		frame_is(i_restore_frame.format, FRAME_PENDING_EXCEPTION_FRAME);

	wire pending = (state == UNIT_PENDING);
	wire take_pend = i_op_valid && pending;

	wire is_pre = (i_op.opclass == OPCLASS_0) || (i_op.opclass == OPCLASS_2);
	wire is_post = (i_op.opclass == OPCLASS_3);
	wire signalling_nan_exc_en = fp_control_reg[CTL_SIGNALLING_NAN_EXC_BIT];
	wire operand_error_exc_en = fp_control_reg[CTL_OPERAND_ERROR_EXC_BIT];
	// masking is full for all destination formats: no forced trap
	wire signalling_nan_exc_trap = i_op.signalling_nan_exc && signalling_nan_exc_en;
	wire operand_error_exc_trap = i_op.operand_error_exc && operand_error_exc_en;
	// product quirk: counted as underflow even though result is normal
	wire unfl_cond = i_op.unfl || i_mul_zero_exp;
	wire unfl_trap = unfl_cond && fp_control_reg[CTL_UNFL_BIT];
	wire ovfl_trap = i_op.ovfl && fp_control_reg[CTL_OVFL_BIT];
	wire nan_op_trap = signalling_nan_exc_trap || operand_error_exc_trap;
	wire op_live = i_op_valid && !pending;
	wire pre_trap = op_live && nan_op_trap && is_pre;
	wire post_trap = op_live && nan_op_trap && is_post;
	wire arith_trap = op_live && !nan_op_trap && (unfl_trap || ovfl_trap);
	// signalling_nan_exc has priority over operand error when both are present and enabled
	wire [7:0] nan_vec = signalling_nan_exc_trap ? VEC_SIGNALLING_NAN_EXC : VEC_OPERAND_ERROR_EXC;
	wire [7:0] arith_vec = ovfl_trap ? VEC_OVFL : VEC_UNFL;
	wire [7:0] next_vec = take_pend ? pend_vec :
		(arith_trap ? arith_vec : nan_vec);
	wire next_take = take_pend || pre_trap || post_trap || arith_trap;
	// destination written by a live (not pending) op unless a pre-instruction trap stops it
	wire next_we = op_live && !pre_trap;
	wire [79:0] next_data = (i_op.signalling_nan_exc || i_op.operand_error_exc) ? i_op.default_result :
		i_op.dst_ext;
	wire next_capture = pre_trap || post_trap;

	////////////////////////////////////////////////////////////////////////
	// unit state
	// an exceptional frame beats a save in the same cycle; pending and
	// the frame format are registered so the outputs come from flops
	always_comb begin
		next_state = state;
		unique case (state)
			UNIT_IDLE: begin
				if (rest_pending_exception_frame) begin
					next_state = UNIT_PENDING;
				end
			end
			UNIT_PENDING: begin
				if (rest_pending_exception_frame) begin
					next_state = UNIT_PENDING;
				end else if (rest_null || rest_idle || i_save_valid) begin
					next_state = UNIT_IDLE;
				end
			end
			// two-bit code leaves two patterns unused
			default: begin
				next_state = UNIT_IDLE;
			end
		endcase
	end

	wire next_pend = (next_state == UNIT_PENDING);
	wire [7:0] next_fmt = next_pend ? FRAME_PENDING_EXCEPTION_FRAME : FRAME_IDLE;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= UNIT_IDLE;
			pend_flag <= 1'b0;
			frame_fmt <= FRAME_IDLE;
		end else begin
			state <= next_state;
			pend_flag <= next_pend;
			frame_fmt <= next_fmt;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_vec <= 8'h00;
		end else if (rest_pending_exception_frame) begin
			pend_vec <= i_restore_frame.vector;
		end
	end

	// saved operand for the frame; overflow/underflow leave it invalid
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			saved_src <= 80'h0;
			saved_valid <= 1'b0;
		end else if (next_capture) begin
			saved_src <= i_op.src_ext;
			saved_valid <= 1'b1;
		end else if (arith_trap || rest_null || i_save_valid) begin
			saved_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// programmer-visible registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fp_control_reg <= 32'h0;
		end else if (rest_null) begin
			fp_control_reg <= 32'h0;
		end else if (i_ctl_we) begin
			fp_control_reg <= i_ctl_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fp_status_reg <= 32'h0;
		end else if (rest_null) begin
			fp_status_reg <= 32'h0;
		end else if (op_live) begin
			fp_status_reg[STS_SIGNALLING_NAN_EXC_BIT] <= fp_status_reg[STS_SIGNALLING_NAN_EXC_BIT] |
				i_op.signalling_nan_exc;
			fp_status_reg[STS_OPERAND_ERROR_EXC_BIT] <= fp_status_reg[STS_OPERAND_ERROR_EXC_BIT] |
				i_op.operand_error_exc;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fp_instr_address_reg <= 32'h0;
		end else if (rest_null) begin
			o_fp_instr_address_reg <= 32'h0;
		end else if (op_live) begin
			// address of the last op run, for the handlers
			o_fp_instr_address_reg <= i_op.iaddr;
		end
	end

	// data registers: no reset, hence a plain array; null restore floods
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < NREGS; k++) begin
			if (rest_null) begin
				data_reg[k] <= QUIET_NAN;
			end else if (next_we && (i_op.dst_reg == 3'(k))) begin
				data_reg[k] <= next_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_exc <= '0;
			o_illegal <= 1'b0;
			o_dst_we <= 1'b0;
			o_dst_reg <= 3'h0;
			o_dst_data <= 80'h0;
			o_reg_rdata <= 80'h0;
		end else begin
			o_exc.take <= next_take;
			o_exc.pre <= take_pend || pre_trap || arith_trap;
			o_exc.vector <= next_take ? next_vec : 8'h00;
			o_illegal <= bad_restore;
			o_dst_we <= next_we;
			o_dst_reg <= i_op.dst_reg;
			o_dst_data <= next_data;
			o_reg_rdata <= data_reg[i_reg_rsel];
		end
	end

	always_comb begin
		o_pending = pend_flag;
		o_fp_control_reg = fp_control_reg;
		o_fp_status_reg = fp_status_reg;
		o_save_frame.valid = saved_valid;
		o_save_frame.format = frame_fmt;
		o_save_frame.vector = pend_vec;
		o_save_frame.operand = saved_src;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	signalling_nan_exc_vector_a: assert property (op_live && signalling_nan_exc_trap |=>
		o_exc.take && o_exc.vector == 8'h36)
		else $error("signalling_nan_exc vector wrong");
	operand_error_exc_vector_a: assert property (op_live && !i_op.signalling_nan_exc && operand_error_exc_trap |=>
		o_exc.vector == 8'h34)
		else $error("operand error vector wrong");
	pre_blocks_a: assert property (pre_trap |=> o_exc.pre && !o_dst_we)
		else $error("pre-instruction trap wrote destination");
	post_writes_a: assert property (post_trap |=> !o_exc.pre && o_dst_we)
		else $error("post-instruction trap missed write");
	frame_valid_a: assert property (next_capture |=>
		o_save_frame.valid && o_save_frame.operand == $past(i_op.src_ext))
		else $error("save frame not captured");
	masked_quiet_a: assert property (op_live && (i_op.signalling_nan_exc || i_op.operand_error_exc) &&
		!signalling_nan_exc_en && !operand_error_exc_en && !(unfl_trap || ovfl_trap) |=> !o_exc.take)
		else $error("masked exception trapped");
	mul_unfl_a: assert property (op_live && i_mul_zero_exp &&
		fp_control_reg[CTL_UNFL_BIT] && !nan_op_trap |=> o_exc.take)
		else $error("product quirk not trapped");
	null_clear_a: assert property (rest_null |=>
		o_fp_control_reg == 32'h0 && o_fp_status_reg == 32'h0 &&
		o_fp_instr_address_reg == 32'h0)
		else $error("null restore left registers");
	idle_keep_a: assert property (rest_idle && !i_ctl_we |=>
		!o_pending && $stable(o_fp_control_reg))
		else $error("idle restore disturbed state");
	pending_exception_frame_pend_a: assert property (rest_pending_exception_frame |=>
		o_pending && o_save_frame.vector == $past(i_restore_frame.vector))
		else $error("exceptional restore not pending");
	pend_take_a: assert property (take_pend |=>
		o_exc.take && o_exc.vector == $past(pend_vec))
		else $error("pending exception not taken");
	save_idle_a: assert property (pending && i_save_valid && !do_restore
		|=> !o_pending) else $error("save did not clear pending");
	pend_hold_a: assert property (pending && !i_save_valid && !do_restore
		|=> o_pending) else $error("pending dropped early");
	bad_mode_a: assert property (bad_restore |=> o_illegal &&
		$stable(o_fp_status_reg) && $stable(o_pending))
		else $error("illegal restore changed state");
	decode_a: assert property (i_restore_valid &&
		i_restore_opword[15:6] == 10'h3CD && i_restore_opword[5:3] == 3'h0
		|=> o_illegal) else $error("data register form accepted");
	legal_mode_a: assert property (i_restore_valid &&
		i_restore_opword[15:6] == 10'h3CD && i_restore_opword[5:3] == 3'h3
		|=> !o_illegal) else $error("postincrement form refused");
	illegal_only_a: assert property (!bad_restore |=> !o_illegal)
		else $error("illegal flagged without cause");

	// restore bookkeeping: only a null frame may touch status
	status_keep_a: assert property (do_restore && !rest_null &&
		!op_live |=> $stable(o_fp_status_reg))
		else $error("status changed by restore");
	ctl_keep_a: assert property (rest_pending_exception_frame && !i_ctl_we |=>
		$stable(o_fp_control_reg))
		else $error("exceptional restore changed control");
	null_nan_a: assert property (rest_null |=> ##1
		o_reg_rdata == 80'h7FFF_FFFF_FFFF_FFFF_FFFF)
		else $error("null restore left a data register");

	// op side: a pending op runs nothing, masked ops give the default
	pend_nowrite_a: assert property (take_pend && !rest_null |=>
		!o_dst_we && $stable(o_fp_status_reg))
		else $error("pending op executed");
	masked_default_a: assert property (op_live && i_op.signalling_nan_exc &&
		!signalling_nan_exc_en && !operand_error_exc_en |=> o_dst_we &&
		o_dst_data == $past(i_op.default_result))
		else $error("masked result not the default");
	arith_frame_a: assert property (arith_trap |=>
		!o_save_frame.valid) else $error("overflow trap supplied operand");

	c_pre: cover property (pre_trap);
	c_arith: cover property (arith_trap);
	c_post: cover property (post_trap);
	c_pend: cover property (rest_pending_exception_frame ##[1:5] take_pend);
	c_null: cover property (rest_null);

endmodule : fpu_exception_state_restore
`default_nettype wire

// ### verif/int_pipe_model.sv
/*
 * Integer pipeline model: issues fp ops, saves, restores, control writes.
 * Assumes the unit answers one cycle after the taking edge.
 */
`timescale 1ns/1ps
`default_nettype none
module int_pipe_model (
	input wire logic i_clk,
	output logic o_op_valid,
	output fpu_exc_pkg::fp_op_t o_op,
	output logic o_mul_zero_exp,
	output logic o_save_valid,
	output logic o_restore_valid,
	output logic [15:0] o_restore_opword,
	output fpu_exc_pkg::restore_frame_t o_restore_frame,
	output logic o_ctl_we,
	output logic [31:0] o_ctl_wdata
);
	import fpu_exc_pkg::*;
	initial begin
		{o_op_valid, o_op, o_mul_zero_exp, o_save_valid} = '0;
		{o_restore_valid, o_restore_opword, o_restore_frame} = '0;
		{o_ctl_we, o_ctl_wdata} = '0;
	end
	////////////////////////////////////////////////////////////////////
	// released data lines show the inverse, never the stale value; strobes and o_mul_zero_exp drop to 0
	task issue(input fp_op_t op, input logic mz);
		@(posedge i_clk);
		o_op_valid <= 1'b1;
		o_op <= op;
		o_mul_zero_exp <= mz;
		@(posedge i_clk);
		o_op_valid <= 1'b0;
		o_op <= ~op;
		o_mul_zero_exp <= 1'b0;
	endtask : issue
	task restore(input logic [15:0] w, input restore_frame_t f);
		@(posedge i_clk);
		o_restore_valid <= 1'b1;
		o_restore_opword <= w;
		o_restore_frame <= f;
		@(posedge i_clk);
		o_restore_valid <= 1'b0;
		o_restore_opword <= ~w;
		o_restore_frame <= ~f;
	endtask : restore
	task save();
		@(posedge i_clk);
		o_save_valid <= 1'b1;
		@(posedge i_clk);
		o_save_valid <= 1'b0;
	endtask : save
	task ctl(input logic [31:0] d);
		@(posedge i_clk);
		o_ctl_we <= 1'b1;
		o_ctl_wdata <= d;
		@(posedge i_clk);
		o_ctl_we <= 1'b0;
		o_ctl_wdata <= ~d;
	endtask : ctl
endmodule : int_pipe_model
`default_nettype wire

// ### verif/fpu_exception_state_restore_tb.sv
/*
 * Self-checking bench: table of ops, then restore/save hand tests.
 * Assumes the partner model drives every design input but clock, reset and i_reg_rsel.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
	num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module fpu_exception_state_restore_tb;
	import fpu_exc_pkg::*;
	typedef struct packed {
		logic [31:0] ctl;
		logic [2:0] oc;
		logic [3:0] fl;
		logic mz, take, pre;
		logic [7:0] vec;
		logic we, fv;
	} row_t;
	logic i_clk = 1'b0, i_rst = 1'b1;
	logic i_op_valid, i_mul_zero_exp, i_save_valid, i_restore_valid;
	logic i_ctl_we, o_illegal, o_dst_we, o_pending;
	fp_op_t i_op;
	restore_frame_t i_restore_frame;
	logic [15:0] i_restore_opword;
	logic [31:0] i_ctl_wdata, o_fp_control_reg, o_fp_status_reg, o_iar, s;
	logic [2:0] i_reg_rsel = 3'h3, o_dst_reg;
	exc_req_t o_exc;
	save_frame_t o_save_frame;
	logic [79:0] o_dst_data, o_reg_rdata;
	int num_errors = 0, comparisons = 0;
	fp_op_t op;
	logic [2:0] m;
	row_t rows [8] = '{
		'{32'h4000, 3'h0, 4'h8, 0, 1, 1, 8'h36, 0, 1},
		'{32'h2000, 3'h2, 4'h4, 0, 1, 1, 8'h34, 0, 1},
		'{32'h4000, 3'h3, 4'h8, 0, 1, 0, 8'h36, 1, 1},
		'{32'h2000, 3'h3, 4'h4, 0, 1, 0, 8'h34, 1, 1},
		'{32'h0000, 3'h0, 4'h8, 0, 0, 0, 8'h00, 1, 0},
		'{32'h0000, 3'h3, 4'h4, 0, 0, 0, 8'h00, 1, 0},
		'{32'h1000, 3'h0, 4'h2, 0, 1, 1, 8'h35, 1, 0},
		'{32'h0800, 3'h0, 4'h0, 1, 1, 1, 8'h33, 1, 0}};
	initial forever #2 i_clk = ~i_clk;
	int_pipe_model pipe (.i_clk(i_clk), .o_op_valid(i_op_valid), .o_op(i_op),
		.o_mul_zero_exp(i_mul_zero_exp), .o_save_valid(i_save_valid),
		.o_restore_valid(i_restore_valid), .o_restore_opword(i_restore_opword),
		.o_restore_frame(i_restore_frame), .o_ctl_we(i_ctl_we),
		.o_ctl_wdata(i_ctl_wdata));
	fpu_exception_state_restore dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_op_valid(i_op_valid), .i_op(i_op), .i_mul_zero_exp(i_mul_zero_exp),
		.i_save_valid(i_save_valid), .i_restore_valid(i_restore_valid),
		.i_restore_opword(i_restore_opword), .i_restore_frame(i_restore_frame),
		.i_ctl_we(i_ctl_we), .i_ctl_wdata(i_ctl_wdata), .i_reg_rsel(i_reg_rsel),
		.o_exc(o_exc), .o_illegal(o_illegal), .o_dst_we(o_dst_we),
		.o_dst_reg(o_dst_reg), .o_dst_data(o_dst_data),
		.o_save_frame(o_save_frame), .o_pending(o_pending),
		.o_fp_control_reg(o_fp_control_reg), .o_fp_status_reg(o_fp_status_reg),
		.o_fp_instr_address_reg(o_iar), .o_reg_rdata(o_reg_rdata));
	////////////////////////////////////////////////////////////////////
	task close_out();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	// bound well above the roughly 120 cycles the tests need
	initial begin
		#40000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		pipe.ctl(32'h0000_7800);
		pipe.restore(16'hF350, '{FRAME_NULL, 8'h00});
		#1;
		`CHK(o_fp_control_reg, 32'h0)
		`CHK(o_fp_status_reg, 32'h0)
		`CHK(o_iar, 32'h0)
		`CHK(o_illegal, 1'b0)
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(o_reg_rdata, QUIET_NAN)
		foreach (rows[i]) begin
			pipe.ctl(rows[i].ctl);
			op = '{rows[i].oc, rows[i].fl[3], rows[i].fl[2], rows[i].fl[1],
				rows[i].fl[0], {16'h4000, 60'h0, i[3:0]}, 80'h1,
				{16'h7FFF, 60'h0, i[3:0]}, 3'h1, {28'h0000001, i[3:0]}};
			pipe.issue(op, rows[i].mz);
			#1;
			`CHK(o_exc, {rows[i].take, rows[i].pre, rows[i].vec})
			`CHK(o_dst_we, rows[i].we)
			if (rows[i].take) `CHK(o_save_frame.valid, rows[i].fv)
			if (rows[i].fv) `CHK(o_save_frame.operand, op.src_ext)
			if (!rows[i].take) `CHK(o_dst_data, op.default_result)
		end
		// pending from an exceptional frame, then save returns to idle
		pipe.restore(16'hF368, '{FRAME_PENDING_EXCEPTION_FRAME, VEC_OPERAND_ERROR_EXC});
		#1;
		`CHK(o_pending, 1'b1)
		`CHK(o_fp_control_reg, 32'h0800)
		`CHK(o_save_frame.format, FRAME_PENDING_EXCEPTION_FRAME)
		op.signalling_nan_exc = 1'b0;
		op.ovfl = 1'b0;
		pipe.issue(op, 1'b0);
		#1;
		`CHK(o_exc, {1'b1, 1'b1, VEC_OPERAND_ERROR_EXC})
		`CHK(o_dst_we, 1'b0)
		`CHK(o_pending, 1'b1)
		pipe.save();
		#1;
		`CHK(o_pending, 1'b0)
		`CHK(o_save_frame.format, FRAME_IDLE)
		// back to pending, then an idle frame clears it
		pipe.restore(16'hF368, '{FRAME_PENDING_EXCEPTION_FRAME, VEC_SIGNALLING_NAN_EXC});
		#1;
		`CHK(o_pending, 1'b1)
		s = o_fp_status_reg;
		pipe.restore(16'hF37A, '{FRAME_IDLE, 8'h00});
		#1;
		`CHK(o_pending, 1'b0)
		`CHK(o_illegal, 1'b0)
		`CHK(o_save_frame.format, FRAME_IDLE)
		`CHK(o_fp_status_reg, s)
		`CHK(o_fp_control_reg, 32'h0800)
		// every mode code, an out-of-range register, then a wrong pattern
		for (int k = 0; k < 10; k++) begin
			m = (k < 8) ? k[2:0] : 3'h7;
			pipe.restore({k == 9 ? 10'h3CE : 10'h3CD, m, k == 8 ? 3'h4 : 3'h0},
				'{FRAME_PENDING_EXCEPTION_FRAME, VEC_SIGNALLING_NAN_EXC});
			#1;
			`CHK(o_illegal, m < 2 || m == 4 || k > 7)
			`CHK(o_pending, !(m < 2 || m == 4 || k > 7))
			pipe.save();
		end
		// late null restore floods registers that ops have written
		i_reg_rsel <= 3'h1;
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(o_reg_rdata, 80'h1)
		`CHK(o_iar, 32'h17)
		pipe.restore(16'hF358, '{FRAME_NULL, 8'h00});
		@(posedge i_clk);
		#1;
		`CHK(o_iar, 32'h0)
		`CHK(o_reg_rdata, QUIET_NAN)
		// mid-run reset drops a pending frame and the control word
		pipe.ctl(32'h0000_4000);
		pipe.restore(16'hF368, '{FRAME_PENDING_EXCEPTION_FRAME, VEC_OPERAND_ERROR_EXC});
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(o_pending, 1'b0)
		`CHK(o_save_frame.format, FRAME_IDLE)
		`CHK(o_fp_control_reg, 32'h0)
		`CHK(o_exc, 10'h000)
		@(posedge i_clk);
		i_rst <= 1'b0;
		pipe.issue(op, 1'b0);
		#1;
		`CHK(o_exc.take, 1'b0)
		`CHK(o_dst_we, 1'b1)
		close_out();
	end
endmodule : fpu_exception_state_restore_tb
`default_nettype wire
